/* File: src/pio_pkg.sv */
`default_nettype none
package pio_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int unsigned NUM_PORTS  = 10;
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned BUS_WIDTH  = 32;
    localparam int unsigned ADDR_WIDTH = 8;

    // ************************************************************
    // Address decode
    // ************************************************************
    localparam int unsigned IDX_MSB     = 7;
    localparam int unsigned IDX_LSB     = 2;
    localparam int unsigned IDX_WIDTH   = IDX_MSB - IDX_LSB + 1;
    localparam logic [5:0]  VALUE_IDX_0 = 6'h00;
    localparam logic [5:0]  DIR_IDX_0   = 6'h01;
    localparam logic [5:0]  IDX_STRIDE  = 6'h02;
    localparam logic [5:0]  IDX_LAST    = 6'h13;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] VALUE_RESET      = 8'h00;
    localparam logic [7:0] DIR_RESET_INPUT  = 8'h00;
    localparam logic [7:0] DIR_RESET_OUTPUT = 8'hFF;
    localparam logic [7:0] SENSE_RESET      = 8'h00;
    localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;

endpackage
`default_nettype wire

/* File: src/pio_port_slice.sv */
`default_nettype none
module pio_port_slice
    import pio_pkg::*;
#(
    parameter logic [pio_pkg::PORT_WIDTH-1:0] DIR_RESET = pio_pkg::DIR_RESET_INPUT
) (
    input  wire logic                           clk_sys_i,
    input  wire logic                           rst_b_i,
    input  wire logic                           value_wr_i,
    input  wire logic                           dir_wr_i,
    input  wire logic [pio_pkg::PORT_WIDTH-1:0] wdata_i,
    input  wire logic [pio_pkg::PORT_WIDTH-1:0] pin_sense_i,
    output logic      [pio_pkg::PORT_WIDTH-1:0] pin_drive_o,
    output logic      [pio_pkg::PORT_WIDTH-1:0] drive_enable_n_o,
    output logic      [pio_pkg::PORT_WIDTH-1:0] dir_o,
    output logic      [pio_pkg::PORT_WIDTH-1:0] level_o
);
    import pio_pkg::*;

    logic [PORT_WIDTH-1:0] value_reg;
    logic [PORT_WIDTH-1:0] dir_reg;
    logic [PORT_WIDTH-1:0] sync1_reg;
    logic [PORT_WIDTH-1:0] sync2_reg;
    logic [PORT_WIDTH-1:0] sync3_reg;
    logic [PORT_WIDTH-1:0] level_reg;

    // ************************************************************
    // Software-owned registers
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            value_reg <= VALUE_RESET;
        end else if (value_wr_i) begin
            value_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_reg <= DIR_RESET;
        end else if (dir_wr_i) begin
            dir_reg <= wdata_i;
        end
    end

    // ************************************************************
    // Pad input capture
    // ************************************************************
    // Pads are asynchronous; a bit moves only once stages two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= SENSE_RESET;
            sync2_reg <= SENSE_RESET;
            sync3_reg <= SENSE_RESET;
        end else begin
            sync1_reg <= pin_sense_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_reg <= SENSE_RESET;
        end else begin
            level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
        end
    end

    // Value drives pads always; enable decides whether the pad drives it
    assign pin_drive_o      = value_reg;
    assign drive_enable_n_o = ~dir_reg;
    assign dir_o            = dir_reg;
    assign level_o          = level_reg;

endmodule
`default_nettype wire

/* File: src/pio_ports.sv */
// Summary of operation
// - Eighty pins are provided as ten independent eight-bit ports A through J.
// - Each pin is set as input or output by its own direction bit.
// - After reset ports A, C, E, G and I are inputs and B, D, F, H and J are outputs.
// - Each port owns an eight-bit value register and an eight-bit direction register.
// - Reading a value register returns the pin levels of all eight pins.
// - Writing a value register sets the levels driven on output pins.
// - The active-low reset returns all registers to their defaults.
// - Register decode uses address bits seven down to two only.
// - Read data is captured only for a selected read access.
// - A write access with byte lane zero enabled stores data and a read access returns data.
// - The block acts on the bus only while it is selected.
// - A pin is driven only while its direction bit is one.
// - Each port gives eight active-low output enables from its direction register.
// - Each port takes eight pad inputs and returns them as value read data.
`default_nettype none
module pio_ports
    import pio_pkg::*;
(
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_b_i,
    input  wire logic [pio_pkg::ADDR_WIDTH-1:0]  avs_address_i,
    input  wire logic                            avs_read_i,
    input  wire logic                            avs_write_i,
    input  wire logic [pio_pkg::BUS_WIDTH-1:0]   avs_writedata_i,
    input  wire logic [3:0]                      avs_byteenable_i,
    output logic      [pio_pkg::BUS_WIDTH-1:0]   avs_readdata_o,
    output logic                                 avs_waitrequest_o,
    input  wire logic [pio_pkg::NUM_PORTS*pio_pkg::PORT_WIDTH-1:0] port_pin_sense_i,
    output logic      [pio_pkg::NUM_PORTS*pio_pkg::PORT_WIDTH-1:0] port_pin_drive_o,
    output logic      [pio_pkg::NUM_PORTS*pio_pkg::PORT_WIDTH-1:0] port_drive_enable_n_o
);
    import pio_pkg::*;

    logic                  ack_reg;
    logic [BUS_WIDTH-1:0]  rdata_reg;
    logic [BUS_WIDTH-1:0]  rdata_next;
    logic                  select;
    logic                  wr_fire;
    logic [IDX_WIDTH-1:0]  idx;
    logic [NUM_PORTS-1:0]  value_wr;
    logic [NUM_PORTS-1:0]  dir_wr;
    logic [PORT_WIDTH-1:0] level_all [NUM_PORTS];
    logic [PORT_WIDTH-1:0] dir_all   [NUM_PORTS];

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [IDX_WIDTH-1:0] value_idx(input int unsigned port);
        value_idx = VALUE_IDX_0 + IDX_STRIDE * port[IDX_WIDTH-1:0];
    endfunction

    function automatic logic [IDX_WIDTH-1:0] dir_idx(input int unsigned port);
        dir_idx = DIR_IDX_0 + IDX_STRIDE * port[IDX_WIDTH-1:0];
    endfunction

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // One wait state per access: read data is registered before release
    assign select            = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = select & ~ack_reg;
    assign wr_fire           = avs_write_i & ack_reg & avs_byteenable_i[0];
    assign idx               = avs_address_i[IDX_MSB:IDX_LSB];

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= select & ~ack_reg;
        end
    end

    always_comb begin
        rdata_next = RDATA_UNMAPPED;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (idx == value_idx(p)) begin
                rdata_next[PORT_WIDTH-1:0] = level_all[p];
            end
            if (idx == dir_idx(p)) begin
                rdata_next[PORT_WIDTH-1:0] = dir_all[p];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= RDATA_UNMAPPED;
        end else if (avs_read_i && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata_o = rdata_reg;

    // ************************************************************
    // Ports A to J
    // ************************************************************
    generate
        for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
            localparam logic [PORT_WIDTH-1:0] DIR_DEF =
                (g % 2 == 0) ? DIR_RESET_INPUT : DIR_RESET_OUTPUT;

            assign value_wr[g] = wr_fire && (idx == value_idx(g));
            assign dir_wr[g]   = wr_fire && (idx == dir_idx(g));

            pio_port_slice #(
                .DIR_RESET (DIR_DEF)
            ) u_slice (
                .clk_sys_i        (clk_sys_i),
                .rst_b_i          (rst_b_i),
                .value_wr_i       (value_wr[g]),
                .dir_wr_i         (dir_wr[g]),
                .wdata_i          (avs_writedata_i[PORT_WIDTH-1:0]),
                .pin_sense_i      (port_pin_sense_i[g*PORT_WIDTH +: PORT_WIDTH]),
                .pin_drive_o      (port_pin_drive_o[g*PORT_WIDTH +: PORT_WIDTH]),
                .drive_enable_n_o (port_drive_enable_n_o[g*PORT_WIDTH +: PORT_WIDTH]),
                .dir_o            (dir_all[g]),
                .level_o          (level_all[g])
            );
        end
    endgenerate

endmodule
`default_nettype wire

/* File: test/pio_bridge_model.sv */
`default_nettype none
module pio_bridge_model (
    input  wire logic        clk_sys_i,
    input  wire logic        waitrequest_i,
    input  wire logic [31:0] readdata_i,
    output logic      [7:0]  address_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] writedata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {address_o, read_o, write_o, writedata_o} = '0;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge clk_sys_i);
        address_o <= a;
        read_o <= !wr;
        write_o <= wr;
        writedata_o <= {24'h0, d};
        // No cycle limit here: only the bench watchdog may end a stuck wait
        do begin
            @(posedge clk_sys_i);
        end while (waitrequest_i !== 1'b0);
        q = readdata_i;
        {read_o, write_o} <= 2'b00;
        // Released data must not look like the last value
        writedata_o <= ~writedata_o;
    endtask
endmodule
`default_nettype wire

/* File: test/pio_ports_chk.sv */
`default_nettype none
module pio_ports_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [79:0] port_pin_drive_o,
    input wire logic [79:0] port_drive_enable_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    wire logic       req = avs_read_i || avs_write_i;
    wire logic       dn  = req && !avs_waitrequest_o;
    wire logic       map = avs_address_i < 8'h50;
    wire logic       wv  = dn && avs_write_i && avs_byteenable_i[0] && map;
    wire logic       rv  = dn && avs_read_i;
    wire logic [7:0] at  = {avs_address_i[7:3], 3'h0};
    wire logic [7:0] wd  = avs_writedata_i[7:0];
    sequence taken_s;
        req && avs_waitrequest_o ##1 dn;
    endsequence
    one_wait_a: assert property (req && !$past(req) |-> taken_s)
        else $error("wait");
    idle_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("idle");
    hi_zero_a: assert property (dn |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper");
    val_wr_a: assert property (wv && !avs_address_i[2] |=>
        port_pin_drive_o[$past(at) +: 8] == $past(wd)) else $error("value");
    dir_wr_a: assert property (wv && avs_address_i[2] |=>
        port_drive_enable_n_o[$past(at) +: 8] == ~$past(wd)) else $error("dir");
    dir_rd_a: assert property (rv && map && avs_address_i[2] |->
        avs_readdata_o[7:0] == ~port_drive_enable_n_o[at +: 8]) else $error("dir rd");
    unmap_a: assert property (rv && !map |-> avs_readdata_o == 32'h0)
        else $error("unmapped");
    hold_a: assert property (!wv |=> $stable(port_pin_drive_o) &&
        $stable(port_drive_enable_n_o)) else $error("hold");
    rst_val_a: assert property ($rose(rst_b_i) |-> port_pin_drive_o == 80'h0 &&
        port_drive_enable_n_o == 80'h00FF_00FF_00FF_00FF_00FF) else $error("reset");
endmodule
bind pio_ports pio_ports_chk chk (.*);
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [79:0] EXT = {10{8'h5A}};
    localparam logic [79:0] EN_RST = 80'h00FF_00FF_00FF_00FF_00FF;
    logic        clk_sys_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0]  avs_byteenable_i;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [79:0] port_pin_sense_i, port_pin_drive_o, port_drive_enable_n_o;
    int          fail_count, tests_run;
    // Row: write flag, byte address, write data, expected read byte
    logic [24:0] rows [14] = '{25'h0040000, 25'h00C00FF, 25'h000005A, 25'h108C300,
        25'h00800C3, 25'h1040F00, 25'h1003C00, 25'h000005C, 25'h006000F, 25'h04C00FF,
        25'h0480000, 25'h0500000, 25'h14C0000, 25'h048005A};
    // Pads loop driven pins back, undriven pins see a fixed level
    assign port_pin_sense_i = (port_pin_drive_o & ~port_drive_enable_n_o) |
                              (EXT & port_drive_enable_n_o);
    pio_ports dut (.*);
    pio_bridge_model bridge (.clk_sys_i, .waitrequest_i(avs_waitrequest_o),
        .readdata_i(avs_readdata_o), .address_o(avs_address_i), .read_o(avs_read_i),
        .write_o(avs_write_i), .writedata_o(avs_writedata_i));
    task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] s);
        tests_run++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Work takes about 125 cycles; the 2000-cycle limit is sixteen times that
    initial begin
        #10000;
        fail_count++;
        results();
    end
    initial begin
        fail_count = 0;
        tests_run = 0;
        rst_b_i = 1'b0;
        avs_byteenable_i = 4'h1;
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            // Pad levels pass a synchroniser before they can be read
            repeat (4) @(posedge clk_sys_i);
            bridge.xfer(rows[i][24], rows[i][23:16], rows[i][15:8], q);
            if (!rows[i][24]) chk("read", {72'h0, rows[i][7:0]}, {48'h0, q});
        end
        $display("test register rows done");
        chk("b drive", 80'hC3, {72'h0, port_pin_drive_o[15:8]});
        chk("a enable", 80'hF0, {72'h0, port_drive_enable_n_o[7:0]});
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("reset drive", 80'h0, port_pin_drive_o);
        chk("reset enable", EN_RST, port_drive_enable_n_o);
        rst_b_i <= 1'b1;
        bridge.xfer(1'b1, 8'h50, 8'hFF, q);
        @(posedge clk_sys_i);
        chk("unmapped", EN_RST, port_drive_enable_n_o);
        // Lane 0 disabled: the write is acknowledged but must not land
        avs_byteenable_i <= 4'h0;
        bridge.xfer(1'b1, 8'h08, 8'hA5, q);
        @(posedge clk_sys_i);
        chk("masked write", 80'h0, {72'h0, port_pin_drive_o[15:8]});
        avs_byteenable_i <= 4'h1;
        $display("test reset, unmapped and masked write done");
        results();
    end
endmodule
`default_nettype wire
